// ### include/sdrat_pkg.sv
// Shared constants and types for the read-path and row-activation timing block
package sdrat_pkg;

    // Clock and timing figures, times in picoseconds
    localparam int TCK_PS = 40000;
    localparam int T_RAS_PS = 40000;
    localparam int T_RTP_PS = 7500;
    localparam int T_RP_PS = 15000;

    // Least times round up to whole cycles and never fall below one
    localparam int RAS_CLK_RAW = (T_RAS_PS + TCK_PS - 1) / TCK_PS;
    localparam int RTP_CLK_RAW = (T_RTP_PS + TCK_PS - 1) / TCK_PS;
    localparam int RP_CLK_RAW = (T_RP_PS + TCK_PS - 1) / TCK_PS;
    localparam int RAS_CLK = (RAS_CLK_RAW < 1) ? 1 : RAS_CLK_RAW;
    localparam int RTP_CLK = (RTP_CLK_RAW < 1) ? 1 : RTP_CLK_RAW;
    localparam int RP_CLK = (RP_CLK_RAW < 1) ? 1 : RP_CLK_RAW;
    // Precharge after a read waits the larger of the read-to-precharge time and two clocks
    localparam int RTP_HOLD = (RTP_CLK > 2) ? RTP_CLK : 2;
    localparam int PREFETCH_OFS = 2;

    // Geometry
    localparam int NBANK = 8;
    localparam int BANK_W = 3;
    localparam int ROW_W = 14;
    localparam int COL_W = 10;
    localparam int DQ_W = 8;
    localparam int AP_BIT = 10;
    localparam int MAX_RL = 11;
    localparam int CNT_W = 5;

    // Clocks per burst, one rise/fall data pair per clock
    localparam logic [2:0] BL4_BEATS = 3'h2;
    localparam logic [2:0] BL8_BEATS = 3'h4;

    typedef enum logic [2:0]
    {
        SDRAT_NOP = 3'b000,
        SDRAT_ACT = 3'b001,
        SDRAT_RD = 3'b010,
        SDRAT_WR = 3'b011,
        SDRAT_PRE = 3'b100
    } sdrat_cmd_t;

    typedef struct packed
    {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] ba;
        logic [ROW_W-1:0] addr;
    } sdrat_cabus_t;

    typedef struct packed
    {
        logic valid;
        logic [BANK_W-1:0] ba;
        logic [COL_W-1:0] col;
    } sdrat_rdq_t;

    typedef struct packed
    {
        logic [DQ_W-1:0] dq_rise;
        logic [DQ_W-1:0] dq_fall;
        logic dq_oe;
        logic dqs_rise;
        logic dqs_fall;
        logic dqs_oe;
        logic last;
    } sdrat_dout_t;

endpackage

// ### hw/sdrat_bank.sv
// One bank: open row, active-time and precharge timers, auto precharge
`timescale 1ns/100ps
`default_nettype none
module sdrat_bank
    import sdrat_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic act,
    input wire logic rd,
    input wire logic rd_ap,
    input wire logic pre,
    input wire logic [ROW_W-1:0] row,
    input wire logic [2:0] al,
    input wire logic [2:0] beats,
    output logic open_r,
    output logic [ROW_W-1:0] row_r,
    output logic busy_r
);
    logic [CNT_W-1:0] ras_left_r;
    logic [CNT_W-1:0] ap_left_r;
    logic [CNT_W-1:0] rp_left_r;
    logic ap_pend_r;
    logic ap_fire;

    // Internal precharge only once both the burst offset and active time are met
    assign ap_fire = ap_pend_r && (ap_left_r == '0) && (ras_left_r == '0);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            open_r <= 1'b0;
            row_r <= '0;
        end
        else if (act)
        begin
            open_r <= 1'b1;
            row_r <= row;
        end
        else if (pre || ap_fire)
        begin
            open_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            ras_left_r <= '0;
        else if (act)
            ras_left_r <= CNT_W'(RAS_CLK - 1);
        else if (ras_left_r != '0)
            ras_left_r <= ras_left_r - 1'b1;
    end

    // A read without auto precharge leaves the row open and cancels any pending close
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ap_pend_r <= 1'b0;
            ap_left_r <= '0;
        end
        else if (rd)
        begin
            ap_pend_r <= rd_ap;
            ap_left_r <= CNT_W'(al) + CNT_W'(beats) + CNT_W'(RTP_HOLD - PREFETCH_OFS - 1);
        end
        else if (ap_fire || pre)
        begin
            ap_pend_r <= 1'b0;
        end
        else if (ap_left_r != '0)
        begin
            ap_left_r <= ap_left_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rp_left_r <= '0;
            busy_r <= 1'b0;
        end
        else if (pre || ap_fire)
        begin
            rp_left_r <= CNT_W'(RP_CLK - 1);
            busy_r <= 1'b1;
        end
        else if (rp_left_r != '0)
        begin
            rp_left_r <= rp_left_r - 1'b1;
        end
        else
        begin
            busy_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### hw/sdrat_core.sv
// Device-side command decode, bank array and read-burst data/strobe generation
`timescale 1ns/100ps
`default_nettype none
module sdrat_core
    import sdrat_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire sdrat_cabus_t ca,
    input wire logic [2:0] al,
    input wire logic [2:0] cl,
    input wire logic bl8,
    output sdrat_dout_t dout_r,
    output logic [NBANK-1:0] bank_open_r,
    output logic [NBANK-1:0] bank_busy_r
);
    sdrat_cmd_t cmd;
    sdrat_rdq_t pipe_r [MAX_RL];
    sdrat_rdq_t tap;
    sdrat_rdq_t pre_tap;
    logic [3:0] rl;
    logic [2:0] beats;
    logic [2:0] left_r;
    logic [2:0] left_nxt;
    logic [1:0] beat_r;
    logic [COL_W-1:0] col_r;
    logic [BANK_W-1:0] ba_r;
    logic go;
    logic [1:0] s_beat;
    logic [COL_W-1:0] s_col;
    logic [BANK_W-1:0] s_ba;
    sdrat_dout_t dout_nxt;

    function automatic sdrat_cmd_t sdrat_decode(input sdrat_cabus_t c);
        sdrat_cmd_t r;
        r = SDRAT_NOP;
        if (!c.cs_n)
        begin
            unique case ({c.ras_n, c.cas_n, c.we_n})
                3'b011: r = SDRAT_ACT;
                3'b101: r = SDRAT_RD;
                3'b100: r = SDRAT_WR;
                3'b010: r = SDRAT_PRE;
                default: r = SDRAT_NOP;
            endcase
        end
        return r;
    endfunction

    // Sequential burst order wrapping within the burst-aligned column block
    function automatic logic [DQ_W-1:0] sdrat_elem(input logic [COL_W-1:0] col,
                                                   input logic [2:0] k,
                                                   input logic b8,
                                                   input logic [BANK_W-1:0] ba);
        logic [COL_W-1:0] c;
        c = col;
        if (b8)
            c[2:0] = col[2:0] + k;
        else
            c[1:0] = col[1:0] + k[1:0];
        return c[DQ_W-1:0] ^ {ba, 5'h00};
    endfunction

    // Out-of-range latency codes are clamped to 3 at the low end and to the pipeline depth at the high end
    function automatic logic [3:0] sdrat_rl(input logic [2:0] a, input logic [2:0] c);
        logic [3:0] s;
        s = {1'b0, a} + {1'b0, c};
        if (s > 4'(MAX_RL))
            s = 4'(MAX_RL);
        if (s < 4'h3)
            s = 4'h3;
        return s;
    endfunction

    assign cmd = sdrat_decode(ca);
    assign rl = sdrat_rl(al, cl);
    assign beats = bl8 ? BL8_BEATS : BL4_BEATS;

    // Read command delay line; tap RL-1 starts data, RL-2 starts preamble
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pipe_r[0] <= '0;
        else
            pipe_r[0] <= '{valid: (cmd == SDRAT_RD), ba: ca.ba, col: ca.addr[COL_W-1:0]};
    end

    genvar gi;
    generate
        for (gi = 1; gi < MAX_RL; gi++)
        begin : g_pipe
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                    pipe_r[gi] <= '0;
                else
                    pipe_r[gi] <= pipe_r[gi-1];
            end
        end
    endgenerate

    assign tap = pipe_r[rl - 4'h1];
    assign pre_tap = pipe_r[rl - 4'h2];

    // A newly arriving read replaces any burst still running
    always_comb
    begin
        go = 1'b0;
        s_beat = 2'h0;
        s_col = col_r;
        s_ba = ba_r;
        left_nxt = 3'h0;
        if (tap.valid)
        begin
            go = 1'b1;
            s_col = tap.col;
            s_ba = tap.ba;
            left_nxt = beats - 3'h1;
        end
        else if (left_r != 3'h0)
        begin
            go = 1'b1;
            s_beat = beat_r + 2'h1;
            left_nxt = left_r - 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            left_r <= 3'h0;
            beat_r <= 2'h0;
            col_r <= '0;
            ba_r <= '0;
        end
        else
        begin
            left_r <= left_nxt;
            beat_r <= s_beat;
            col_r <= s_col;
            ba_r <= s_ba;
        end
    end

    always_comb
    begin
        dout_nxt = '0;
        dout_nxt.dq_rise = go ? sdrat_elem(s_col, {s_beat, 1'b0}, bl8, s_ba) : '0;
        dout_nxt.dq_fall = go ? sdrat_elem(s_col, {s_beat, 1'b1}, bl8, s_ba) : '0;
        dout_nxt.dq_oe = go;
        dout_nxt.dqs_rise = go;
        dout_nxt.dqs_fall = 1'b0;
        // Preamble only where no data is already flowing, so chained bursts stay seamless
        dout_nxt.dqs_oe = go || pre_tap.valid;
        dout_nxt.last = go && (left_nxt == 3'h0);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            dout_r <= '0;
        else
            dout_r <= dout_nxt;
    end

    generate
        for (gi = 0; gi < NBANK; gi++)
        begin : g_bank
            logic hit;
            assign hit = (ca.ba == BANK_W'(gi));
            sdrat_bank u_bank
            (
                .core_clk(core_clk),
                .nrst(nrst),
                .act((cmd == SDRAT_ACT) && hit),
                .rd((cmd == SDRAT_RD) && hit),
                .rd_ap(ca.addr[AP_BIT]),
                .pre((cmd == SDRAT_PRE) && (hit || ca.addr[AP_BIT])),
                .row(ca.addr),
                .al(al),
                .beats(beats),
                .open_r(bank_open_r[gi]),
                .row_r(),
                .busy_r(bank_busy_r[gi])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// ### verif/sdrat_ctl_model.sv
// Controller model that turns bench requests into command-bus cycles
`timescale 1ns/100ps
`default_nettype none
module sdrat_ctl_model
    import sdrat_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire sdrat_cmd_t k,
    input wire logic [2:0] b,
    input wire logic [ROW_W-1:0] a,
    output var sdrat_cabus_t ca
);
    logic [NBANK-1:0] op_r;
    logic [2:0] rcw;
    // An activate to an open bank or a read to a closed bank goes out as a no-op
    always_comb
    begin
        case (k)
            SDRAT_ACT: rcw = op_r[b] ? 3'h7 : 3'h3;
            SDRAT_RD: rcw = op_r[b] ? 3'h5 : 3'h7;
            SDRAT_WR: rcw = 3'h4;
            SDRAT_PRE: rcw = 3'h2;
            default: rcw = 3'h7;
        endcase
    end
    assign ca = {1'b0, rcw, b, a};
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            op_r <= '0;
        else if (rcw == 3'h3)
            op_r[b] <= 1'b1;
        else if (rcw == 3'h2 || (rcw == 3'h5 && a[AP_BIT]))
            op_r[b] <= 1'b0;
    end
endmodule
`default_nettype wire

// ### verif/sdrat_core_asserts.sv
// Read-path timing checks on the core ports
`timescale 1ns/100ps
`default_nettype none
module sdrat_core_asserts
    import sdrat_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire sdrat_cabus_t ca,
    input wire logic [2:0] al,
    input wire logic [2:0] cl,
    input wire logic bl8,
    input wire sdrat_dout_t dout_r,
    input wire logic [NBANK-1:0] bank_open_r,
    input wire logic [NBANK-1:0] bank_busy_r
);
    logic [3:0] sum;
    logic [3:0] rl;
    logic [14:0] hist_r;
    logic [NBANK-1:0] shut;
    logic rd;
    assign rd = !ca.cs_n && ca.ras_n && !ca.cas_n && ca.we_n;
    assign sum = {1'b0, al} + {1'b0, cl};
    assign rl = (sum < 4'h3) ? 4'h3 : ((sum > 4'hb) ? 4'hb : sum);
    // Bit n set: a read was taken n+1 edges ago
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            hist_r <= '0;
        else
            hist_r <= {hist_r[13:0], rd};
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_pre;
        dout_r.dqs_oe && !dout_r.dqs_rise && !dout_r.dqs_fall;
    endsequence
    sequence s_four;
        dout_r.dq_oe [*4];
    endsequence
    a_first_data: assert property (hist_r[rl] |-> dout_r.dq_oe)
        else $error("no data at read latency");
    a_read_pre: assert property (hist_r[rl-1] && !dout_r.dq_oe |-> s_pre)
        else $error("missing preamble");
    a_post_amble: assert property (dout_r.last |-> dout_r.dq_oe && !dout_r.dqs_fall)
        else $error("bad postamble");
    a_strobe_data: assert property (dout_r.dq_oe |-> dout_r.dqs_oe && dout_r.dqs_rise)
        else $error("strobe not with data");
    // Strobe may stay driven only as the preamble of the next read
    a_bus_release: assert property ($fell(dout_r.dq_oe) |-> $past(dout_r.last)
        && (!dout_r.dqs_oe || hist_r[rl-1]))
        else $error("bad release");
    a_last_four: assert property (!bl8 && hist_r[rl+1] && !hist_r[rl-1] |-> dout_r.last)
        else $error("burst of four not ended");
    a_last_eight: assert property (bl8 && hist_r[rl+3]
        && !hist_r[rl+1] && !hist_r[rl-1] |-> dout_r.last)
        else $error("burst of eight not ended");
    a_len_eight: assert property ($rose(dout_r.dq_oe) && bl8 |-> s_four)
        else $error("burst of eight too short");
    a_rd_open: assert property (rd && !ca.addr[AP_BIT] && bank_open_r[ca.ba]
        |-> ##2 bank_open_r[$past(ca.ba, 2)])
        else $error("row closed by plain read");
    assign shut = ~bank_open_r;
    a_close_busy: assert property (($past(bank_open_r) & shut) != '0
        |-> (bank_busy_r & $past(bank_open_r) & shut) == ($past(bank_open_r) & shut))
        else $error("closed bank not in precharge");
endmodule
bind sdrat_core sdrat_core_asserts u_chk (.core_clk(core_clk), .nrst(nrst), .ca(ca), .al(al),
    .cl(cl), .bl8(bl8), .dout_r(dout_r), .bank_open_r(bank_open_r), .bank_busy_r(bank_busy_r));
`default_nettype wire

// ### verif/sdrat_activate_read_timing_bench.sv
// Self-checking bench for the read-burst timing core
`timescale 1ns/100ps
`default_nettype none
module sdrat_activate_read_timing_bench
    import sdrat_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    sdrat_cmd_t k = SDRAT_NOP;
    logic [2:0] b = 3'h0;
    logic [ROW_W-1:0] a = '0;
    logic [2:0] al = 3'h1;
    logic [2:0] cl = 3'h3;
    logic bl8 = 1'b0;
    sdrat_cabus_t ca;
    sdrat_dout_t dout_r;
    logic [NBANK-1:0] bank_open_r;
    logic [NBANK-1:0] bank_busy_r;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int last_rd = 0;
    logic [31:0] seed = 32'ha6c36027;
    logic [31:0] r;
    logic [15:0] q[$];
    sdrat_ctl_model u_ctl (.core_clk(core_clk), .nrst(nrst), .k(k), .b(b), .a(a), .ca(ca));
    sdrat_core dut (.core_clk(core_clk), .nrst(nrst), .ca(ca), .al(al), .cl(cl), .bl8(bl8),
        .dout_r(dout_r), .bank_open_r(bank_open_r), .bank_busy_r(bank_busy_r));
    always #20 core_clk = ~core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Burst element i: low column bits wrap inside the aligned block
    function automatic logic [7:0] elem(input logic [9:0] c, input logic [2:0] ba, input int i);
        logic [9:0] m;
        logic [9:0] v;
        m = bl8 ? 10'h7 : 10'h3;
        v = (c & ~m) | ((c + 10'(i)) & m);
        return v[7:0] ^ {ba, 5'h0};
    endfunction
    // Drive one request for one cycle, then no-ops, sp cycles in all
    task automatic cmd(input sdrat_cmd_t kk, input logic [2:0] bb, input logic [13:0] aa, int sp);
        int i;
        k = kk;
        b = bb;
        a = aa;
        if (kk == SDRAT_RD)
        begin
            if (bl8 && cyc - last_rd == 2)
                repeat (2) void'(q.pop_back());
            last_rd = cyc;
            for (i = 0; i < (bl8 ? 8 : 4); i += 2)
                q.push_back({elem(aa[9:0], bb, i), elem(aa[9:0], bb, i + 1)});
        end
        @(negedge core_clk);
        if (sp > 1)
            k = SDRAT_NOP;
        repeat (sp - 1) @(negedge core_clk);
    endtask
    task automatic rst_open(input logic b8);
        int j;
        nrst = 1'b0;
        bl8 = b8;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        check(32'(bank_open_r), 32'h0);
        for (j = 0; j < 4; j++)
            cmd(SDRAT_ACT, j[2:0], 14'(rnd()), j == 3 ? 4 : 2);
        check(32'(bank_open_r), 32'hf);
    endtask
    task automatic reads(input int n);
        repeat (n)
        begin
            r = rnd();
            cmd(SDRAT_RD, {1'b0, r[1:0]}, {4'h0, r[11:2]},
                bl8 ? (r[13] ? 2 : 4 + r[12]) : 2 + r[13:12]);
        end
        cmd(SDRAT_NOP, 3'h0, 14'h0, 14);
        check(32'(q.size()), 32'h0);
    endtask
    always @(negedge core_clk)
    begin
        if (nrst && dout_r.dq_oe === 1'b1)
        begin
            if (q.size() == 0)
                check(32'h1, 32'h0);
            else
                check(32'({dout_r.dq_rise, dout_r.dq_fall}), 32'(q.pop_front()));
        end
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            errors++;
            print_verdict();
        end
    end
    initial
    begin
        @(negedge core_clk);
        rst_open(1'b0);
        reads(24);
        cmd(SDRAT_RD, 3'h3, 14'h0405, 12);
        check(32'({bank_open_r, bank_busy_r}), 32'h0700);
        cmd(SDRAT_RD, 3'h2, 14'h0010, 3);
        cmd(SDRAT_PRE, 3'h2, 14'h0, 1);
        check(32'({bank_open_r, bank_busy_r}), 32'h0304);
        cmd(SDRAT_NOP, 3'h0, 14'h0, 4);
        check(32'({bank_busy_r, 8'(q.size())}), 32'h0);
        cmd(SDRAT_WR, 3'h0, 14'h0, 12);
        al = 3'h0;
        cl = 3'h5;
        rst_open(1'b1);
        reads(16);
        print_verdict();
    end
endmodule
`default_nettype wire
